// ==== ulst_link_model.sv ====
`timescale 1ns/1ns
module ulst_link_model
(
    input wire logic clk_i,
    input wire logic dir_i,
    input wire logic nxt_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic stp_o
);
    logic [7:0] drv = 8'h00;
    logic dir_q = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rxcmd = 8'h00;
    logic rx_act = 1'b0;
    logic pkt_drop = 1'b0;
    int n_rx = 0;
    int aborts = 0;
    // ****************************************************************
    // released bus shows the complement, not a held value
    // ****************************************************************
    assign data_o = dir_i ? ~drv : drv;
    initial stp_o = 1'b0;
    always @(posedge clk_i)
    begin
        dir_q <= dir_i;
        if (dir_i && dir_q && !nxt_i && !rd_q)
        begin
            rxcmd <= data_i;
            n_rx <= n_rx + 1;
            rx_act <= data_i[4];
            if (data_i[5:4] == 2'h3)
                pkt_drop <= 1'b1;
        end
        else if (dir_i && nxt_i && !dir_q)
        begin
            rx_act <= 1'b1;
            pkt_drop <= 1'b0;
        end
        else if (!dir_i)
            rx_act <= 1'b0;
    end
    task automatic reg_write(input logic ext, input logic [7:0] a, input logic [7:0] v);
        logic ok;
        ok = 1'b0;
        while (!ok)
        begin
            @(posedge clk_i);
            while (dir_i) @(posedge clk_i);
            drv <= {2'b10, ext ? 6'h2F : a[5:0]};
            repeat (2) @(posedge clk_i);
            if (ext && !dir_i && nxt_i)
            begin
                drv <= a;
                @(posedge clk_i);
            end
            if (!dir_i && nxt_i)
            begin
                drv <= v;
                @(posedge clk_i);
                if (!dir_i && nxt_i)
                begin
                    drv <= 8'h00;
                    stp_o <= 1'b1;
                    @(posedge clk_i);
                    ok = !dir_i;
                end
            end
            drv <= 8'h00;
            stp_o <= 1'b0;
            if (!ok)
                aborts++;
        end
    endtask
    task automatic reg_read(input logic [5:0] a, output logic [7:0] v);
        logic ok;
        ok = 1'b0;
        while (!ok)
        begin
            @(posedge clk_i);
            while (dir_i) @(posedge clk_i);
            drv <= {2'b11, a};
            rd_q <= 1'b1;
            repeat (2) @(posedge clk_i);
            ok = nxt_i && !dir_i;
            drv <= 8'h00;
            repeat (2) @(posedge clk_i);
            ok = ok && dir_i && !nxt_i;
            v = data_i;
            rd_q <= 1'b0;
            if (!ok)
                aborts++;
        end
    endtask
endmodule // ulst_link_model

// ==== ulst_monitor.sv ====
`timescale 1ns/1ns
module ulst_monitor
    import ulst_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] ulpi_data_i,
    input wire logic [7:0] ulpi_data_o,
    input wire logic ulpi_data_oe_o,
    input wire logic ulpi_dir_o,
    input wire logic ulpi_nxt_o,
    input wire logic session_valid_i,
    input wire logic a_vld_i,
    input wire logic host_disc_i,
    input wire logic rx_sync_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_done_i,
    input wire logic rx_err_i
);
    // ****************************************************************
    // link side checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rxc = ulpi_dir_o && !ulpi_nxt_o && ulpi_data_oe_o;
    a_sync_dir_nxt: assert property (rx_sync_i && !ulpi_dir_o |=> ulpi_dir_o && ulpi_nxt_o)
        else $error("sync did not raise dir and nxt");
    a_byte_passes: assert property (ulpi_dir_o && rx_byte_valid_i && !rx_err_i && !rx_done_i
        |=> ulpi_nxt_o && ulpi_data_o == $past(rx_data_i))
        else $error("received byte not passed with nxt");
    a_err_event: assert property (rx_err_i && ulpi_dir_o |=> rxc && ulpi_data_o[5:4] == EVT_ERROR)
        else $error("receive error not reported");
    a_done_event: assert property (rx_done_i && ulpi_dir_o && !host_disc_i
        |=> rxc && ulpi_data_o[5:4] == EVT_IDLE ##1 !ulpi_dir_o)
        else $error("end of packet not reported idle");
    a_turn_cycle: assert property ($rose(ulpi_dir_o) |-> !ulpi_data_oe_o ##1 ulpi_data_oe_o)
        else $error("bus turnaround wrong");
    a_txcmd_answer: assert property (!ulpi_dir_o && !ulpi_nxt_o && ulpi_data_i[7]
        |-> ##[1:4] (ulpi_nxt_o || ulpi_dir_o))
        else $error("register command not answered");
    a_hdisc_rxcmd: assert property ($changed(host_disc_i) && !ulpi_dir_o |-> ##[1:12]
        (rxc && ulpi_data_o[5:4] == (host_disc_i ? EVT_HDISC : EVT_IDLE)))
        else $error("host disconnect change not reported");
    a_vbus_rxcmd: assert property ($changed(a_vld_i) && session_valid_i
        |-> ##[1:12] (rxc && ulpi_data_o[3:2] == {1'b1, a_vld_i}))
        else $error("supply state change not reported");
    c_receive: cover property (ulpi_dir_o && ulpi_nxt_o);
    c_error: cover property (rx_err_i && ulpi_dir_o);
    c_abort: cover property (ulpi_nxt_o && !ulpi_dir_o ##1 ulpi_dir_o);
endmodule // ulst_monitor

bind ulst_top ulst_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .ulpi_data_i(ulpi_data_i),
    .ulpi_data_o(ulpi_data_o), .ulpi_data_oe_o(ulpi_data_oe_o), .ulpi_dir_o(ulpi_dir_o),
    .ulpi_nxt_o(ulpi_nxt_o), .session_valid_i(session_valid_i), .a_vld_i(a_vld_i),
    .host_disc_i(host_disc_i), .rx_sync_i(rx_sync_i), .rx_byte_valid_i(rx_byte_valid_i),
    .rx_data_i(rx_data_i), .rx_done_i(rx_done_i), .rx_err_i(rx_err_i));

// ==== ulst_pkg.sv ====
// What this block does
// - send an RXCMD whenever the encoded VBUS state changes with its change enable set
// - RxEvent: 00 idle, 01 active, 11 active with error, 10 host disconnect
// - receive active shown by DIR with NXT, or by an RXCMD; link accepts both
// - receive error: drop NXT, send RXCMD with error bit; link drops packet
// - host disconnect reported only while both data-line pulldowns are enabled
// - host disconnect changes send an RXCMD when its change enables are set
// - accept immediate and extended register addressing
// - register access aborts when DIR rises during it; link retries
// - VBUS state: 00 below end, 01 below valid, 10 below A-valid, 11 above
// - RXCMD byte holds VBUS state in bits 3..2 and RxEvent in bits 5..4
package ulst_pkg;
    // ****************************************************************
    // register indices (byte address is index times four)
    // ****************************************************************
    localparam logic [5:0] REG_FUNC_CTRL = 6'h04;
    localparam logic [5:0] REG_INTERFACE_CONTROL_REG = 6'h07;
    localparam logic [5:0] REG_OTG_CONTROL_REG = 6'h0A;
    localparam logic [5:0] REG_RISE_EN = 6'h0D;
    localparam logic [5:0] REG_FALL_EN = 6'h10;
    localparam logic [5:0] REG_STATUS = 6'h13;
    localparam logic [5:0] REG_EXT_ADDR = 6'h2F;
    localparam int NUM_REGS = 5;
    localparam logic [2:0] SLOT_FUNC = 3'h0;
    localparam logic [2:0] SLOT_INTF = 3'h1;
    localparam logic [2:0] SLOT_OTG = 3'h2;
    localparam logic [2:0] SLOT_RISE = 3'h3;
    localparam logic [2:0] SLOT_FALL = 3'h4;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_FUNC = 8'h41;
    localparam logic [7:0] RST_INTF = 8'h00;
    localparam logic [7:0] RST_OTG = 8'h06;
    localparam logic [7:0] RST_RISE = 8'h1F;
    localparam logic [7:0] RST_FALL = 8'h1F;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int INTF_INVERT_BIT = 5;
    localparam int INTF_PASS_BIT = 6;
    localparam int OTG_PD_PLUS_BIT = 1;
    localparam int OTG_PD_MINUS_BIT = 2;
    localparam int OTG_USE_EXT_BIT = 7;
    // change enable bits, shared by both enable registers
    localparam int EV_AVLD = 0;
    localparam int EV_SVLD = 1;
    localparam int EV_SEND = 2;
    localparam int EV_HDISC = 3;
    localparam int NUM_EV = 4;
    // ****************************************************************
    // rxcmd and txcmd encodings
    // ****************************************************************
    localparam logic [1:0] VB_LOW = 2'h0;
    localparam logic [1:0] VB_END = 2'h1;
    localparam logic [1:0] VB_SVLD = 2'h2;
    localparam logic [1:0] VB_AVLD = 2'h3;
    localparam logic [1:0] EVT_IDLE = 2'h0;
    localparam logic [1:0] EVT_ACTIVE = 2'h1;
    localparam logic [1:0] EVT_ERROR = 2'h3;
    localparam logic [1:0] EVT_HDISC = 2'h2;
    localparam logic [1:0] CMD_REG_WRITE = 2'h2;
    localparam logic [1:0] CMD_REG_READ = 2'h3;
endpackage

// ==== ulst_top.sv ====
`timescale 1ns/1ns
module ulst_top
    import ulst_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // link side pins
    input wire logic [7:0] ulpi_data_i,
    output logic [7:0] ulpi_data_o,
    output logic ulpi_data_oe_o,
    output logic ulpi_dir_o,
    output logic ulpi_nxt_o,
    input wire logic ulpi_stp_i,
    // analog front end
    input wire logic session_ended_i,
    input wire logic session_valid_i,
    input wire logic a_vld_i,
    input wire logic fault_i,
    input wire logic host_disc_i,
    input wire logic id_i,
    input wire logic [1:0] linestate_i,
    input wire logic rx_sync_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_done_i,
    input wire logic rx_err_i
);
    typedef enum logic [3:0] {
        S_IDLE, S_ACK, S_EXT, S_WDATA, S_WSTP, S_RTURN, S_RDATA,
        S_ST_TURN, S_ST_SEND, S_RX_TURN, S_RX, S_RX_END
    } ulst_state_t;

    ulst_state_t st_ff, nxt_st;
    logic [7:0] regs_ff [NUM_REGS];
    logic [7:0] nxt_regs [NUM_REGS];
    logic dir_ff, nxt_dir, nxtsig_ff, nxt_nxtsig;
    logic [7:0] data_ff, nxt_data;
    logic [1:0] cmd_ff, nxt_cmd;
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic pend_ff, nxt_pend;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [1:0] vbus_state;
    logic host_disc;
    logic change;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [3:0] slot_of(input logic [7:0] a);
        // bit 3 flags a hit, bits 2..0 the storage slot
        unique case (a)
            {2'h0, REG_FUNC_CTRL}: slot_of = {1'b1, SLOT_FUNC};
            {2'h0, REG_INTERFACE_CONTROL_REG}: slot_of = {1'b1, SLOT_INTF};
            {2'h0, REG_OTG_CONTROL_REG}: slot_of = {1'b1, SLOT_OTG};
            {2'h0, REG_RISE_EN}: slot_of = {1'b1, SLOT_RISE};
            {2'h0, REG_FALL_EN}: slot_of = {1'b1, SLOT_FALL};
            default: slot_of = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] rxcmd(input logic [1:0] evt);
        rxcmd = {1'b0, id_i, evt, vbus_state, linestate_i};
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [3:0] s;
        s = slot_of(a);
        if (s[3])
            read_reg = regs_ff[s[2:0]];
        else if (a == {2'h0, REG_STATUS})
            read_reg = {5'h00, host_disc, vbus_state};
        else
            read_reg = 8'h00;
    endfunction

    // idle event: host disconnect shows only outside a packet
    logic [1:0] idle_evt;
    assign idle_evt = host_disc ? EVT_HDISC : EVT_IDLE;

    ulst_vbus_events u_events (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .session_ended_i(session_ended_i),
        .session_valid_i(session_valid_i),
        .a_vld_i(a_vld_i),
        .fault_i(fault_i),
        .host_disc_i(host_disc_i),
        .linestate_i(linestate_i),
        .fault_polarity_invert_i(regs_ff[SLOT_INTF][INTF_INVERT_BIT]),
        .use_external_fault_i(regs_ff[SLOT_OTG][OTG_USE_EXT_BIT]),
        .fault_pass_through_i(regs_ff[SLOT_INTF][INTF_PASS_BIT]),
        .plus_line_pulldown_i(regs_ff[SLOT_OTG][OTG_PD_PLUS_BIT]),
        .minus_line_pulldown_i(regs_ff[SLOT_OTG][OTG_PD_MINUS_BIT]),
        .rise_en_i(regs_ff[SLOT_RISE]),
        .fall_en_i(regs_ff[SLOT_FALL]),
        .vbus_state_o(vbus_state),
        .host_disc_o(host_disc),
        .change_o(change)
    );

    // ****************************************************************
    // link state machine
    // ****************************************************************
    always_comb
    begin
        logic [3:0] s;
        logic wb_wr;
        s = 4'h0;
        wb_wr = 1'b0;
        nxt_st = st_ff;
        nxt_dir = dir_ff;
        nxt_nxtsig = 1'b0;
        nxt_data = data_ff;
        nxt_cmd = cmd_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_pend = pend_ff;
        nxt_regs = regs_ff;
        // wishbone: answer one cycle after the request, write at the ack edge
        nxt_ack = cyc_i & stb_i & ~ack_ff;
        nxt_rdat = nxt_ack ? {24'h000000, read_reg({2'h0, adr_i[7:2]})} : rdat_ff;
        wb_wr = cyc_i & stb_i & we_i & ack_ff & sel_i[0];
        s = slot_of({2'h0, adr_i[7:2]});
        if (wb_wr && s[3])
            nxt_regs[s[2:0]] = dat_i[7:0];
        unique case (st_ff)
            S_IDLE:
            begin
                nxt_dir = 1'b0;
                if (rx_sync_i)
                begin
                    nxt_dir = 1'b1;
                    nxt_nxtsig = 1'b1;
                    nxt_st = S_RX_TURN;
                end
                else if (pend_ff)
                begin
                    nxt_dir = 1'b1;
                    nxt_st = S_ST_TURN;
                end
                else if (ulpi_data_i[7])
                begin
                    nxt_cmd = ulpi_data_i[7:6];
                    nxt_addr = {2'h0, ulpi_data_i[5:0]};
                    nxt_nxtsig = 1'b1;
                    nxt_st = S_ACK;
                end
            end
            S_ACK, S_EXT, S_WDATA, S_WSTP:
            begin
                if (rx_sync_i)
                begin
                    nxt_dir = 1'b1;
                    nxt_nxtsig = 1'b1;
                    nxt_st = S_RX_TURN;
                end
                else if (st_ff == S_ACK && addr_ff[5:0] == REG_EXT_ADDR)
                begin
                    nxt_nxtsig = 1'b1;
                    nxt_st = S_EXT;
                end
                else if (st_ff == S_WDATA)
                begin
                    nxt_wdata = ulpi_data_i;
                    nxt_st = S_WSTP;
                end
                else if (st_ff == S_WSTP)
                begin
                    if (ulpi_stp_i)
                    begin
                        s = slot_of(addr_ff);
                        if (s[3])
                            nxt_regs[s[2:0]] = wdata_ff;
                        nxt_st = S_IDLE;
                    end
                end
                else
                begin
                    if (st_ff == S_EXT)
                        nxt_addr = ulpi_data_i;
                    if (cmd_ff == CMD_REG_WRITE)
                    begin
                        nxt_nxtsig = 1'b1;
                        nxt_st = S_WDATA;
                    end
                    else
                    begin
                        nxt_dir = 1'b1;
                        nxt_st = S_RTURN;
                    end
                end
            end
            S_RTURN:
            begin
                nxt_data = read_reg(addr_ff);
                nxt_st = S_RDATA;
            end
            S_ST_TURN:
            begin
                nxt_data = rxcmd(idle_evt);
                nxt_pend = 1'b0;
                nxt_st = S_ST_SEND;
            end
            S_RX_TURN, S_RX:
            begin
                nxt_st = S_RX;
                if (rx_err_i)
                begin
                    nxt_data = rxcmd(EVT_ERROR);
                    nxt_st = S_RX_END;
                end
                else if (rx_done_i)
                begin
                    nxt_data = rxcmd(idle_evt);
                    nxt_st = S_RX_END;
                end
                else if (rx_byte_valid_i)
                begin
                    nxt_nxtsig = 1'b1;
                    nxt_data = rx_data_i;
                end
                else
                    nxt_data = rxcmd(EVT_ACTIVE);
            end
            S_RDATA, S_ST_SEND, S_RX_END:
            begin
                nxt_dir = 1'b0;
                nxt_st = S_IDLE;
            end
        endcase
        if (change)
            nxt_pend = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= S_IDLE;
            dir_ff <= 1'b0;
            nxtsig_ff <= 1'b0;
            data_ff <= 8'h00;
            cmd_ff <= 2'h0;
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            pend_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
            regs_ff[SLOT_FUNC] <= RST_FUNC;
            regs_ff[SLOT_INTF] <= RST_INTF;
            regs_ff[SLOT_OTG] <= RST_OTG;
            regs_ff[SLOT_RISE] <= RST_RISE;
            regs_ff[SLOT_FALL] <= RST_FALL;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
            dir_ff <= nxt_dir;
            nxtsig_ff <= nxt_nxtsig;
            data_ff <= nxt_data;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            pend_ff <= nxt_pend;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            regs_ff <= nxt_regs;
        end
    end

    // data bus driven only after the turnaround cycle
    assign ulpi_data_oe_o = dir_ff && st_ff != S_RTURN && st_ff != S_ST_TURN && st_ff != S_RX_TURN;
    assign ulpi_data_o = data_ff;
    assign ulpi_dir_o = dir_ff;
    assign ulpi_nxt_o = nxtsig_ff;
    assign ack_o = ack_ff;
    assign dat_o = rdat_ff;
endmodule // ulst_top

// ==== ulst_top_bench.sv ====
`timescale 1ns/1ns
module ulst_top_bench
    import ulst_pkg::*;
;
    logic clk_i;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic [7:0] phy_do;
    logic [7:0] link_do;
    logic oe, dir, nxt, stp;
    logic session_ended = 1'b0;
    logic session_valid = 1'b1;
    logic a_vld = 1'b0;
    logic fault = 1'b0;
    logic hdisc = 1'b0;
    logic rx_sync = 1'b0;
    logic rx_bv = 1'b0;
    logic rx_done = 1'b0;
    logic rx_err = 1'b0;
    logic [7:0] rx_data = 8'h00;
    int fails = 0;
    int n_tests = 0;
    wire logic [7:0] bus = oe ? phy_do : link_do;
    // ****************************************************************
    // block, link and checks
    // ****************************************************************
    ulst_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .ulpi_data_i(bus), .ulpi_data_o(phy_do), .ulpi_data_oe_o(oe), .ulpi_dir_o(dir),
        .ulpi_nxt_o(nxt), .ulpi_stp_i(stp), .session_ended_i(session_ended), .session_valid_i(session_valid),
        .a_vld_i(a_vld), .fault_i(fault), .host_disc_i(hdisc), .id_i(1'b0),
        .linestate_i(2'h1), .rx_sync_i(rx_sync), .rx_byte_valid_i(rx_bv), .rx_data_i(rx_data),
        .rx_done_i(rx_done), .rx_err_i(rx_err));
    ulst_link_model lk (.clk_i(clk_i), .dir_i(dir), .nxt_i(nxt), .data_i(bus),
        .data_o(link_do), .stp_o(stp));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
        output logic [7:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h000000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        v = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rxw(input string nm, input logic [7:0] e);
        int c0;
        int k;
        c0 = lk.n_rx;
        k = 0;
        while (lk.n_rx == c0 && k < 40)
        begin
            @(posedge clk_i);
            k++;
        end
        repeat (8) @(posedge clk_i);
        chk(nm, e, (lk.n_rx != c0) ? lk.rxcmd : 8'hXX);
    endtask
    task automatic t_regs();
        logic [7:0] v;
        logic [5:0] ix [5] = '{REG_FUNC_CTRL, REG_INTERFACE_CONTROL_REG, REG_OTG_CONTROL_REG,
            REG_RISE_EN, REG_FALL_EN};
        logic [7:0] rv [5] = '{RST_FUNC, RST_INTF, RST_OTG, RST_RISE, RST_FALL};
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, ix[i], 8'h00, v);
            chk("reset value", rv[i], v);
        end
        wb(1'b1, 6'h3F, 8'h5A, v);
        wb(1'b0, 6'h3F, 8'h00, v);
        chk("unmapped", 8'h00, v);
        lk.reg_read(REG_RISE_EN, v);
        chk("ulpi read", RST_RISE, v);
    endtask
    task automatic t_paths();
        logic [7:0] v;
        lk.reg_write(1'b0, {2'b00, REG_INTERFACE_CONTROL_REG}, 8'h11);
        wb(1'b0, REG_INTERFACE_CONTROL_REG, 8'h00, v);
        chk("immediate write", 8'h11, v);
        lk.reg_write(1'b1, {2'b00, REG_FUNC_CTRL}, 8'h45);
        wb(1'b0, REG_FUNC_CTRL, 8'h00, v);
        chk("extended write", 8'h45, v);
        wb(1'b1, REG_INTERFACE_CONTROL_REG, 8'h00, v);
        lk.reg_read(REG_INTERFACE_CONTROL_REG, v);
        chk("bus write", 8'h00, v);
    endtask
    task automatic t_vbus();
        logic [7:0] v;
        int c0;
        logic [4:0] s [5] = '{{3'b100, VB_LOW}, {3'b000, VB_END}, {3'b010, VB_SVLD},
            {3'b011, VB_AVLD}, {3'b010, VB_SVLD}};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_i);
            {session_ended, session_valid, a_vld} <= s[i][4:2];
            rxw("vbus state", {2'b00, EVT_IDLE, s[i][1:0], 2'b01});
        end
        wb(1'b1, REG_RISE_EN, RST_RISE & ~(8'h01 << EV_SVLD), v);
        wb(1'b1, REG_FALL_EN, RST_FALL & ~(8'h01 << EV_SVLD), v);
        c0 = lk.n_rx;
        session_valid <= 1'b0;
        repeat (20) @(posedge clk_i);
        session_valid <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("masked change", 8'h00, 8'(lk.n_rx - c0));
        wb(1'b1, REG_RISE_EN, RST_RISE, v);
        wb(1'b1, REG_FALL_EN, RST_FALL, v);
    endtask
    task automatic t_fault();
        lk.reg_write(1'b0, {2'b00, REG_INTERFACE_CONTROL_REG}, 8'h01 << INTF_PASS_BIT);
        lk.reg_write(1'b0, {2'b00, REG_OTG_CONTROL_REG}, RST_OTG | (8'h01 << OTG_USE_EXT_BIT));
        rxw("fault pass", {2'b00, EVT_IDLE, VB_AVLD, 2'b01});
        lk.reg_write(1'b0, {2'b00, REG_INTERFACE_CONTROL_REG}, 8'h60);
        rxw("fault invert", {2'b00, EVT_IDLE, VB_SVLD, 2'b01});
        fault <= 1'b1;
        rxw("fault input", {2'b00, EVT_IDLE, VB_AVLD, 2'b01});
        fault <= 1'b0;
        rxw("fault clear", {2'b00, EVT_IDLE, VB_SVLD, 2'b01});
        lk.reg_write(1'b0, {2'b00, REG_INTERFACE_CONTROL_REG}, RST_INTF);
        lk.reg_write(1'b0, {2'b00, REG_OTG_CONTROL_REG}, RST_OTG);
    endtask
    task automatic t_hdisc();
        hdisc <= 1'b1;
        rxw("host disc", {2'b00, EVT_HDISC, VB_SVLD, 2'b01});
        hdisc <= 1'b0;
        rxw("host conn", {2'b00, EVT_IDLE, VB_SVLD, 2'b01});
    endtask
    task automatic t_rx();
        rx_sync <= 1'b1;
        @(posedge clk_i);
        rx_sync <= 1'b0;
        @(posedge clk_i);
        rx_bv <= 1'b1;
        rx_data <= 8'hC3;
        @(posedge clk_i);
        rx_data <= 8'h3C;
        chk("rx active", 8'h01, {7'h00, lk.rx_act});
        @(posedge clk_i);
        rx_bv <= 1'b0;
        rx_err <= 1'b1;
        @(posedge clk_i);
        rx_err <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("rx dropped", 8'h01, {7'h00, lk.pkt_drop});
        chk("rx end", {2'b00, EVT_ERROR, VB_SVLD, 2'b01}, lk.rxcmd);
        chk("rx inactive", 8'h00, {7'h00, lk.rx_act});
    endtask
    task automatic t_abort();
        logic [7:0] v;
        int a0;
        a0 = lk.aborts;
        fork
            lk.reg_write(1'b0, {2'b00, REG_FUNC_CTRL}, 8'h41);
            begin
                repeat (2) @(posedge clk_i);
                rx_sync <= 1'b1;
                @(posedge clk_i);
                rx_sync <= 1'b0;
                repeat (3) @(posedge clk_i);
                rx_done <= 1'b1;
                @(posedge clk_i);
                rx_done <= 1'b0;
            end
        join
        chk("abort seen", 8'h01, {7'h00, lk.aborts != a0});
        wb(1'b0, REG_FUNC_CTRL, 8'h00, v);
        chk("retried write", 8'h41, v);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("[FAIL] run time expected end seen hang");
        test_done();
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_paths();
        t_vbus();
        t_fault();
        t_hdisc();
        t_rx();
        t_abort();
        test_done();
    end
endmodule // ulst_top_bench

// ==== ulst_vbus_events.sv ====
`timescale 1ns/1ns
module ulst_vbus_events
    import ulst_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic session_ended_i,
    input wire logic session_valid_i,
    input wire logic a_vld_i,
    input wire logic fault_i,
    input wire logic host_disc_i,
    input wire logic [1:0] linestate_i,
    input wire logic fault_polarity_invert_i,
    input wire logic use_external_fault_i,
    input wire logic fault_pass_through_i,
    input wire logic plus_line_pulldown_i,
    input wire logic minus_line_pulldown_i,
    input wire logic [7:0] rise_en_i,
    input wire logic [7:0] fall_en_i,
    output logic [1:0] vbus_state_o,
    output logic host_disc_o,
    output logic change_o
);
    logic [NUM_EV-1:0] prev_ff, nxt_prev;
    logic [1:0] ls_ff, nxt_ls;
    logic [1:0] vbus_ff, nxt_vbus;
    logic hd_ff, nxt_hd;
    logic chg_ff, nxt_chg;
    logic fault_act, a_eff;
    logic [NUM_EV-1:0] cur;

    // ****************************************************************
    // qualify, encode and detect changes
    // ****************************************************************
    always_comb
    begin
        fault_act = fault_i ^ fault_polarity_invert_i;
        if (!use_external_fault_i)
            a_eff = a_vld_i;
        else if (fault_pass_through_i)
            a_eff = ~fault_act;
        else
            a_eff = a_vld_i & ~fault_act;
        cur[EV_AVLD] = a_eff;
        cur[EV_SVLD] = session_valid_i;
        cur[EV_SEND] = session_ended_i;
        cur[EV_HDISC] = host_disc_i & plus_line_pulldown_i & minus_line_pulldown_i;
        if (a_eff)
            nxt_vbus = VB_AVLD;
        else if (session_valid_i)
            nxt_vbus = VB_SVLD;
        else if (!session_ended_i)
            nxt_vbus = VB_END;
        else
            nxt_vbus = VB_LOW;
        nxt_hd = cur[EV_HDISC];
        nxt_prev = cur;
        nxt_ls = linestate_i;
        nxt_chg = (|(cur & ~prev_ff & rise_en_i[NUM_EV-1:0]))
            | (|(~cur & prev_ff & fall_en_i[NUM_EV-1:0]))
            | (linestate_i != ls_ff);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_ff <= '0;
            ls_ff <= 2'h0;
            vbus_ff <= VB_LOW;
            hd_ff <= 1'b0;
            chg_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            prev_ff <= nxt_prev;
            ls_ff <= nxt_ls;
            vbus_ff <= nxt_vbus;
            hd_ff <= nxt_hd;
            chg_ff <= nxt_chg;
        end
    end

    assign vbus_state_o = vbus_ff;
    assign host_disc_o = hd_ff;
    assign change_o = chg_ff;
endmodule // ulst_vbus_events
